// ---- gds_defines.svh ----
`ifndef GDS_DEFINES_SVH
`define GDS_DEFINES_SVH

// Register byte offsets
`define GDS_OFF_MISC      8'h34
`define GDS_OFF_DIAG      8'h3c
`define GDS_OFF_IRQ_STAT  8'h40
`define GDS_OFF_IRQ_MASK  8'h44

// Misc control reset value and bit positions
`define GDS_MISC_RST      16'h0006
`define GDS_MISC_MEMT     11
`define GDS_MISC_AUTO     10
`define GDS_MISC_NEG      9
`define GDS_MISC_POS      8

// Diagnostic flag bit positions and sticky flag mask
`define GDS_DF_LOW        0
`define GDS_DF_HIGH       1
`define GDS_DF_FLWR       2
`define GDS_DF_SPI        3
`define GDS_DF_OVR        4
`define GDS_DF_STF        5
`define GDS_DF_MEM        6
`define GDS_DF_AL1        8
`define GDS_DF_AL2        9
`define GDS_DF_STICKY     10'h37c

// Interrupt status bit positions
`define GDS_IRQ_STDONE    0
`define GDS_IRQ_MEMDONE   1
`define GDS_IRQ_FLAG      2

// Timing counts and self-test response threshold
`define GDS_SAMPLE_DIV    1000
`define GDS_ST_SETTLE     4
`define GDS_ST_MIN_DELTA  16'h0100

`endif

// ---- gds_diag_top.sv ----
// How it works
// - Auto self-test drives, measures, decides, restores
// - Auto self-test bit clears when finished
// - Manual bits 10 negative, 01 positive
// - Status bit 5 reports self-test failure
// - Memory test bit starts checksum comparison
// - Status bit 6 reports checksum failure
// - Status read clears flags except supply
// - Persisting fault sets flag next sample
// - Supply flags clear themselves, not by read
// - Bit 1 over-voltage, bit 0 under-voltage
// - Bits 9 and 8 show alarm states
// - Bit 4 flags sensor overrange
// - Bit 3 flags serial transaction failure
// - Bit 2 flags flash write failure
// - Memory test bit clears when finished
`include "gds_defines.svh"
`default_nettype none

module gds_diag_top
  import gds_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = `GDS_SAMPLE_DIV,
  parameter int unsigned ST_SETTLE  = `GDS_ST_SETTLE
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor and fault inputs
  input  wire logic [15:0] rate_output,
  input  wire logic        supply_high,
  input  wire logic        supply_low,
  input  wire logic        alarm1_active,
  input  wire logic        alarm2_active,
  input  wire logic        overrange,
  input  wire logic        spi_fail,
  input  wire logic        flash_write_fail,
  // Checksum engine
  output logic             mem_check_start,
  input  wire logic        mem_check_done,
  input  wire logic        mem_check_match,
  // Stimulus and sampling control
  output logic             stim_pos,
  output logic             stim_neg,
  output logic             sample_hold,
  output logic      [2:0]  data_ready_cfg,
  // Interrupt
  output logic             irq
);

  logic [31:0] prdata_q;      // Registered read data
  logic        setup;         // APB setup phase
  logic        acc;           // APB access phase
  logic        wr;            // Write taking effect
  logic        rd;            // Read completing
  logic        hit;           // Mapped address
  logic [31:0] rd_mux;        // Read data select
  logic [15:0] tick_cnt_q;    // Sample divider
  logic        tick_q;        // Sample cycle pulse
  logic [1:0]  man_q;         // Manual stimulus field
  logic [2:0]  drdy_q;        // Data ready setup bits
  logic        memt_busy_q;   // Memory test running
  logic        mem_start_q;   // Checksum start pulse
  logic        mem_fail_q;    // Last checksum result
  logic        mem_done;      // Checksum finished
  logic        st_start;      // Launch self-test
  logic        st_busy;       // Self-test running
  logic        st_done;       // Self-test finished
  logic        st_fail;       // Self-test result
  logic        auto_pos;      // Auto positive phase
  logic        auto_neg;      // Auto negative phase
  logic        stim_pos_q;    // Positive stimulus drive
  logic        stim_neg_q;    // Negative stimulus drive
  logic [9:0]  flags_q;       // Diagnostic flags
  logic [9:0]  cond;          // Fault conditions
  logic [9:0]  set_vec;       // Flags being set
  logic [9:0]  clr_vec;       // Flags being cleared
  logic [15:0] diag_rd;       // Status read view
  logic [2:0]  irq_stat_q;    // Sticky interrupt bits
  logic [2:0]  irq_mask_q;    // Interrupt enables
  logic [2:0]  irq_set;       // Interrupt events

  // APB phase decode
  assign setup  = psel && !penable;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite && hit;
  assign rd     = acc && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = prdata_q;

  // Address decode
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `GDS_OFF_MISC,
      `GDS_OFF_DIAG,
      `GDS_OFF_IRQ_STAT,
      `GDS_OFF_IRQ_MASK: hit = 1'b1;
      default:           hit = 1'b0;
    endcase
  end

  assign diag_rd = {6'h00, flags_q[9:8], 1'b0, flags_q[6:0]};

  // Read data select
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `GDS_OFF_MISC: begin
        rd_mux[`GDS_MISC_MEMT] = memt_busy_q;
        rd_mux[`GDS_MISC_AUTO] = st_busy;
        rd_mux[`GDS_MISC_NEG]  = man_q[1];
        rd_mux[`GDS_MISC_POS]  = man_q[0];
        rd_mux[2:0]            = drdy_q;
      end
      `GDS_OFF_DIAG:     rd_mux[15:0] = diag_rd;
      `GDS_OFF_IRQ_STAT: rd_mux[2:0]  = irq_stat_q;
      `GDS_OFF_IRQ_MASK: rd_mux[2:0]  = irq_mask_q;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data loaded in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  // Sample cycle divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 16'(SAMPLE_DIV - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // manual field and data ready bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_q  <= 2'(`GDS_MISC_RST >> `GDS_MISC_POS);
      drdy_q <= 3'(`GDS_MISC_RST);
    end else if (wr && paddr == `GDS_OFF_MISC) begin
      man_q  <= pwdata[`GDS_MISC_NEG:`GDS_MISC_POS];
      drdy_q <= pwdata[2:0];
    end
  end

  assign st_start = wr && paddr == `GDS_OFF_MISC
                 && pwdata[`GDS_MISC_AUTO] && !st_busy;

  gds_selftest #(
    .SETTLE    (ST_SETTLE),
    .MIN_DELTA (`GDS_ST_MIN_DELTA)
  ) u_selftest (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (st_start),
    .tick        (tick_q),
    .rate_output (rate_output),
    .busy        (st_busy),
    .done        (st_done),
    .fail        (st_fail),
    .auto_pos    (auto_pos),
    .auto_neg    (auto_neg)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stim_pos_q <= 1'b0;
      stim_neg_q <= 1'b0;
    end else if (st_busy) begin
      stim_pos_q <= auto_pos;
      stim_neg_q <= auto_neg;
    end else begin
      stim_pos_q <= man_q == 2'b01;
      stim_neg_q <= man_q == 2'b10;
    end
  end

  assign stim_pos    = stim_pos_q;
  assign stim_neg    = stim_neg_q;
  assign sample_hold = st_busy;
  assign data_ready_cfg = drdy_q;

  assign mem_done = mem_check_done && memt_busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memt_busy_q <= 1'b0;
      mem_start_q <= 1'b0;
      mem_fail_q  <= 1'b0;
    end else begin
      mem_start_q <= 1'b0;
      if (mem_done) begin
        memt_busy_q <= 1'b0;
        mem_fail_q  <= !mem_check_match;
      end else if (wr && paddr == `GDS_OFF_MISC
                   && pwdata[`GDS_MISC_MEMT] && !memt_busy_q) begin
        memt_busy_q <= 1'b1;
        mem_start_q <= 1'b1;
      end
    end
  end
  assign mem_check_start = mem_start_q;

  always_comb begin
    cond                = 10'h000;
    cond[`GDS_DF_FLWR]  = flash_write_fail;
    cond[`GDS_DF_SPI]   = spi_fail;
    cond[`GDS_DF_OVR]   = overrange;
    cond[`GDS_DF_STF]   = st_fail;
    cond[`GDS_DF_MEM]   = mem_fail_q;
    cond[`GDS_DF_AL1]   = alarm1_active;
    cond[`GDS_DF_AL2]   = alarm2_active;
  end

  // sample-cycle set, results post at once
  always_comb begin
    set_vec = tick_q ? (cond & `GDS_DF_STICKY) : 10'h000;
    if (st_done && st_fail) set_vec[`GDS_DF_STF] = 1'b1;
    if (mem_done && !mem_check_match) set_vec[`GDS_DF_MEM] = 1'b1;
  end

  assign clr_vec = (rd && paddr == `GDS_OFF_DIAG)
                 ? `GDS_DF_STICKY : 10'h000;

  // Diagnostic flag storage, one process for all bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 10'h000;
    end else begin
      flags_q[9:2] <= set_vec[9:2] | (flags_q[9:2] & ~clr_vec[9:2]);
      flags_q[`GDS_DF_HIGH] <= supply_high;
      flags_q[`GDS_DF_LOW]  <= supply_low;
    end
  end

  // Interrupt events
  assign irq_set = {|(set_vec & ~flags_q), mem_done, st_done};

  // Sticky interrupt status, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'b000;
    end else if (wr && paddr == `GDS_OFF_IRQ_STAT) begin
      irq_stat_q <= irq_set | (irq_stat_q & ~pwdata[2:0]);
    end else begin
      irq_stat_q <= irq_set | irq_stat_q;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 3'b000;
    end else if (wr && paddr == `GDS_OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[2:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_auto_req;
    st_start;
  endsequence

  sequence s_mem_req;
    wr && paddr == `GDS_OFF_MISC && pwdata[`GDS_MISC_MEMT] && !memt_busy_q
      && !mem_check_done;
  endsequence

  property p_auto_start;
    s_auto_req |=> st_busy && sample_hold ##1 stim_pos == 1'b0;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("self-test did not start");

  property p_auto_done;
    st_done |-> !st_busy ##1 stim_pos == $past(man_q == 2'b01);
  endproperty
  a_auto_done: assert property (p_auto_done)
    else $error("self-test bit still busy after completion");

  property p_manual;
    !st_busy && man_q == 2'b10 && !st_start |=> stim_neg && !stim_pos;
  endproperty
  a_manual: assert property (p_manual)
    else $error("negative manual stimulus not applied");

  property p_st_flag;
    st_done && st_fail |=> diag_rd[`GDS_DF_STF];
  endproperty
  a_st_flag: assert property (p_st_flag)
    else $error("self-test failure not posted");

  property p_mem_start;
    s_mem_req |=> mem_check_start && memt_busy_q ##1 !mem_check_start;
  endproperty
  a_mem_start: assert property (p_mem_start)
    else $error("memory test start not issued");

  property p_mem_flag;
    mem_done && !mem_check_match |=> diag_rd[`GDS_DF_MEM] && !memt_busy_q;
  endproperty
  a_mem_flag: assert property (p_mem_flag)
    else $error("checksum failure not posted");

  property p_rd_clear;
    rd && paddr == `GDS_OFF_DIAG && set_vec == 10'h000
      |=> flags_q[9:2] == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("status read did not clear flags");

  property p_reset_again;
    tick_q && overrange |=> diag_rd[`GDS_DF_OVR];
  endproperty
  a_reset_again: assert property (p_reset_again)
    else $error("persisting overrange not flagged again");

  property p_supply;
    ##1 flags_q[1:0] == $past({supply_high, supply_low});
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply flags do not follow supply");

  property p_alarm;
    tick_q && alarm2_active |=> diag_rd[`GDS_DF_AL2];
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm 2 state not shown");

  property p_set_wins;
    rd && paddr == `GDS_OFF_DIAG && set_vec[`GDS_DF_SPI]
      |=> diag_rd[`GDS_DF_SPI] && diag_rd[15:10] == 6'h00;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("set lost against clearing read");

endmodule

`default_nettype wire

// ---- gds_host_model.sv ----
`default_nettype none

module gds_host_model (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // Released lines show no stale value
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

`default_nettype wire

// ---- gds_pkg.sv ----
`default_nettype none

package gds_pkg;
  // Self-test sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BASE,
    ST_POS,
    ST_NEG,
    ST_REST
  } gds_st_state_t;
endpackage

`default_nettype wire

// ---- gds_selftest.sv ----
`include "gds_defines.svh"
`default_nettype none

module gds_selftest
  import gds_pkg::*;
#(
  parameter int unsigned  SETTLE    = `GDS_ST_SETTLE,
  parameter logic [15:0]  MIN_DELTA = `GDS_ST_MIN_DELTA
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        start,
  input  wire logic        tick,
  input  wire logic [15:0] rate_output,
  // Results
  output logic             busy,
  output logic             done,
  output logic             fail,
  output logic             auto_pos,
  output logic             auto_neg
);

  gds_st_state_t state_q;   // Sequencer state
  logic [7:0]    cnt_q;     // Sample ticks within a phase
  logic [15:0]   base_q;    // Reading with no stimulus
  logic [15:0]   pos_q;     // Reading under positive stimulus
  logic [15:0]   neg_q;     // Reading under negative stimulus
  logic          done_q;    // Completion pulse
  logic          fail_q;    // Last decision
  logic          last;      // Final tick of a phase
  logic [16:0]   pos_dlt;   // Positive response
  logic [16:0]   neg_dlt;   // Negative response
  logic          pass;      // Both responses big enough

  assign last     = cnt_q == 8'(SETTLE - 1);
  assign pos_dlt  = {pos_q[15], pos_q} - {base_q[15], base_q};
  assign neg_dlt  = {base_q[15], base_q} - {neg_q[15], neg_q};
  assign pass     = ($signed(pos_dlt) >= $signed({1'b0, MIN_DELTA}))
                 && ($signed(neg_dlt) >= $signed({1'b0, MIN_DELTA}));
  assign busy     = state_q != ST_IDLE;
  assign auto_pos = state_q == ST_POS;
  assign auto_neg = state_q == ST_NEG;
  assign done     = done_q;
  assign fail     = fail_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (start) state_q <= ST_BASE;
        ST_BASE: if (tick && last) state_q <= ST_POS;
        ST_POS:  if (tick && last) state_q <= ST_NEG;
        ST_NEG:  if (tick && last) state_q <= ST_REST;
        ST_REST: if (tick && last) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Phase length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      cnt_q <= 8'h00;
    end else if (tick) begin
      cnt_q <= last ? 8'h00 : cnt_q + 8'h01;
    end
  end

  // Capture readings at phase ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q <= 16'h0000;
      pos_q  <= 16'h0000;
      neg_q  <= 16'h0000;
    end else if (tick && last) begin
      case (state_q)
        ST_BASE: base_q <= rate_output;
        ST_POS:  pos_q  <= rate_output;
        ST_NEG:  neg_q  <= rate_output;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_REST) && tick && last;
      if ((state_q == ST_REST) && tick && last) fail_q <= !pass;
    end
  end

  // Phase ends in order
  sequence s_pos_end;
    (state_q == ST_POS) && tick && last;
  endsequence

  property p_st_order;
    @(posedge pclk) disable iff (!presetn)
      s_pos_end |=> (state_q == ST_NEG) && auto_neg && !auto_pos;
  endproperty
  a_st_order: assert property (p_st_order)
    else $error("self-test did not go from positive to negative");

endmodule

`default_nettype wire

// ---- gyro_diagnostics_status_tb_top.sv ----
`default_nettype none

module gyro_diagnostics_status_tb_top
  import gds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DIV   = 10;     // Short sample tick
  localparam int unsigned LIMIT = 20000;  // Hang ceiling in cycles

  // Bus and design signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rate_output;
  logic        sup_hi, sup_lo, al1, al2, ovr, spi_f, fl_f;
  logic        mc_start, mc_done, mc_match, sens_ok, err;
  logic        stim_pos, stim_neg, sample_hold, irq;
  logic [2:0]  dr_cfg;
  int          mismatches, total_checks, cycles, start_cnt;

  // Sensor responds to stimulus only when healthy
  assign rate_output = !sens_ok ? 16'h0000 : stim_pos ? 16'h0200 :
                       stim_neg ? 16'hfe00 : 16'h0000;

  gds_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  gds_diag_top #(.SAMPLE_DIV(DIV), .ST_SETTLE(4)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rate_output(rate_output), .supply_high(sup_hi),
    .supply_low(sup_lo), .alarm1_active(al1), .alarm2_active(al2),
    .overrange(ovr), .spi_fail(spi_f), .flash_write_fail(fl_f),
    .mem_check_start(mc_start), .mem_check_done(mc_done),
    .mem_check_match(mc_match), .stim_pos(stim_pos), .stim_neg(stim_neg),
    .sample_hold(sample_hold), .data_ready_cfg(dr_cfg), .irq(irq));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Checksum start pulses and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (mc_start === 1'b1) start_cnt++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register access helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  task automatic tick();
    repeat (2 * DIV) @(posedge pclk);
  endtask

  // Main sequence
  logic [31:0] mcode [4] = '{32'h200, 32'h100, 32'h300, 32'h000};
  logic [1:0]  mstim [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
  initial begin
    {sup_hi, sup_lo, al1, al2, ovr, spi_f, fl_f} = 7'h0;
    {mc_done, mc_match, sens_ok} = 3'b000;
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    start_cnt    = 0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rc(8'h34, 32'h6);
    rc(8'h3c, 32'h0);
    rc(8'h44, 32'h0);
    chk({29'h0, dr_cfg}, 32'h6);
    chk({31'h0, irq}, 32'h0);
    // Manual stimulus codes, sensor at rest
    // host at rest
    for (int i = 0; i < 4; i++) begin
      wr(8'h34, mcode[i] | 32'h6);
      repeat (2) @(posedge pclk);
      chk({30'h0, stim_neg, stim_pos}, {30'h0, mstim[i]});
      rc(8'h34, mcode[i] | 32'h6);
    end
    // Supply flags clear themselves, survive reads
    for (int i = 0; i < 2; i++) begin
      {sup_hi, sup_lo} <= i ? 2'b01 : 2'b10;
      tick();
      rc(8'h3c, i ? 32'h1 : 32'h2);
      rc(8'h3c, i ? 32'h1 : 32'h2);
      {sup_hi, sup_lo} <= 2'b00;
      repeat (3) @(posedge pclk);
      rc(8'h3c, 32'h0);
    end
    // Fault flags latch, read clears
    {al1, al2, ovr, spi_f, fl_f} <= 5'h1f;
    tick();
    {al1, al2, ovr, spi_f, fl_f} <= 5'h00;
    tick();
    rc(8'h3c, 32'h31c);
    rc(8'h3c, 32'h0);
    ovr <= 1'b1;
    tick();
    rc(8'h3c, 32'h10);
    tick();
    rc(8'h3c, 32'h10);
    ovr <= 1'b0;
    tick();
    wr(8'h3c, 32'h0);
    i_host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
    tick();
    rc(8'h3c, 32'h0);
    // Memory test, fail then pass
    for (int i = 0; i < 2; i++) begin
      wr(8'h34, 32'h806);
      rc(8'h34, 32'h806);
      mc_match <= i[0];
      mc_done  <= 1'b1;
      @(posedge pclk);
      mc_done  <= 1'b0;
      repeat (2) @(posedge pclk);
      rc(8'h34, 32'h6);
      i_host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
      tick();
      rc(8'h3c, i ? 32'h0 : 32'h40);
      chk(start_cnt, i + 1);
    end
    // Automatic self-test, fail then pass
    for (int i = 0; i < 2; i++) begin
      sens_ok <= i[0];
      wr(8'h34, 32'h406);
      repeat (2) @(posedge pclk);
      chk({31'h0, sample_hold}, 32'h1);
      for (int k = 0; k < 100; k++) begin
        i_host.xfer(1'b0, 8'h34, 32'h0, rd, err);
        if (rd[10] === 1'b0) break;
        repeat (DIV) @(posedge pclk);
      end
      chk(rd, 32'h6);
      chk({31'h0, sample_hold}, 32'h0);
      i_host.xfer(1'b0, 8'h3c, 32'h0, rd, err);
      tick();
      rc(8'h3c, i ? 32'h0 : 32'h20);
    end
    // Interrupt: raise, mask, clear
    rc(8'h40, 32'h7);
    wr(8'h40, 32'h7);
    rc(8'h40, 32'h0);
    ovr <= 1'b1;
    tick();
    ovr <= 1'b0;
    chk({31'h0, irq}, 32'h0);
    wr(8'h44, 32'h4);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rc(8'h40, 32'h4);
    wr(8'h40, 32'h4);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // Unmapped address
    i_host.xfer(1'b0, 8'h50, 32'h0, rd, err);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    stop_test();
  end
endmodule

`default_nettype wire
